// ===== design/wtp_watchdog.sv
`timescale 1ns/100ps


module wtp_watchdog
  import wtp_pkg::*;
#(
  parameter int OSC_KHZ = OSC_KHZ_DEF,
  parameter int RST_PULSE = RST_PULSE_DEF
)
(
  input wire logic mclk,                 // System clock, 200 MHz
  input wire logic resetn,               // Synchronous reset, active low
  input wire logic [7:0] addr,           // Register address
  input wire logic [7:0] wdata,          // Register write data
  input wire logic wr,                   // Write strobe
  input wire logic rd,                   // Read strobe
  output logic [7:0] rdata,              // Read data, cycle after rd
  input wire logic pll_option,           // Nonvolatile PLL option pin
  output logic sys_reset_n,              // System reset request, active low
  output logic pll_active,               // PLL engaged
  output logic slow_tick,                // Slow-mode prescaler pulse
  output logic halt_tick                 // Active-halt prescaler pulse
);

  // Source divider ratios in mclk cycles per source period
  localparam int DIV_ON = MCLK_KHZ / (2 * OSC_KHZ);
  localparam int DIV_OFF = (2 * MCLK_KHZ) / OSC_KHZ;
  localparam bit PLL_OK = (OSC_KHZ >= PLL_MIN_KHZ) && (OSC_KHZ <= PLL_MAX_KHZ);
  localparam logic [15:0] DIV_ON_M1 = 16'(DIV_ON - 1);
  localparam logic [15:0] DIV_OFF_M1 = 16'(DIV_OFF - 1);
  localparam logic [7:0] RST_PULSE_M1 = 8'(RST_PULSE - 1);

  // Timebase code to constant pair
  function automatic wtp_tb_const_t tb_lookup(input logic [1:0] sel);
    wtp_tb_const_t c;
    c = TB_2MS;
    unique case (sel)
      2'h0: c = TB_2MS;
      2'h1: c = TB_4MS;
      2'h2: c = TB_10MS;
      2'h3: c = TB_25MS;
    endcase
    return c;
  endfunction

  // Timeout bound in source periods, minimum or maximum
  function automatic logic [DLY_W-1:0] tmo_bound(input logic [5:0] cnt, input wtp_tb_const_t c,
                                                 input logic is_max);
    logic [5:0] q;
    logic [7:0] k;
    logic short_cnt;
    logic [DLY_W-1:0] base;
    logic [DLY_W-1:0] seg;
    logic [DLY_W-1:0] part;
    q = c.msb >> 2;
    k = {cnt, 2'b00} / {2'b00, c.msb};
    short_cnt = is_max ? (cnt <= q) : (cnt < q);
    if (is_max)
      base = PRESC_PERIODS;
    else
      base = (DLY_W'(c.lsb) + MIN_BASE_ADD) << SEG_SHIFT;
    part = (SEG_ADD + DLY_W'(c.lsb)) << SEG_SHIFT;
    if (short_cnt)
      seg = DLY_W'(cnt) << PRESC_W;
    else
      seg = ((DLY_W'(cnt) - DLY_W'(k)) << PRESC_W) + DLY_W'(part * DLY_W'(k));
    return base + seg;
  endfunction

  // Option pin synchroniser and strap capture
  logic opt_s1_ff;
  logic opt_s2_ff;
  logic opt_s3_ff;
  logic [1:0] fill_ff;
  logic opt_done_ff;
  logic pll_on_ff;

  // Source clock enable divider
  logic [15:0] div_ff;
  logic src_tick_ff;
  logic [15:0] div_lim;

  // Prescaler taps
  logic [PRESC_W-1:0] phase;
  logic wdg_tick;

  // Control state
  logic [5:0] reload_count_ff;
  logic [1:0] timebase_select_ff;
  logic armed_ff;
  logic rst_flag_ff;
  logic [DLY_W-1:0] remain_ff;
  logic [6:0] ticks_ff;
  logic [7:0] pulse_ff;
  logic sys_reset_n_ff;
  logic [7:0] rdata_ff;
  logic pll_active_ff;

  // Timeout evaluation
  wtp_tb_const_t tbc;
  logic [DLY_W-1:0] dmin;
  logic [DLY_W-1:0] dmax;
  logic [DLY_W+PRESC_W-1:0] spread;
  logic [DLY_W-1:0] nxt_remain;
  logic ctrl_wr;
  logic load;
  logic expire;

  // Three-stage sample of the option pin; fill count marks when all stages hold real pin samples
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      opt_s1_ff <= 1'b0;
      opt_s2_ff <= 1'b0;
      opt_s3_ff <= 1'b0;
      fill_ff <= 2'h0;
    end
    else
    begin
      opt_s1_ff <= pll_option;
      opt_s2_ff <= opt_s1_ff;
      opt_s3_ff <= opt_s2_ff;
      if (fill_ff != 2'h3)
        fill_ff <= fill_ff + 2'h1;
    end
  end

  // Option is caught once after reset, then frozen
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      opt_done_ff <= 1'b0;
      pll_on_ff <= 1'b0;
    end
    else if (!opt_done_ff && (fill_ff == 2'h3) && (opt_s2_ff == opt_s3_ff))
    begin
      opt_done_ff <= 1'b1;
      pll_on_ff <= opt_s3_ff && PLL_OK;
    end
  end

  // PLL doubles the oscillator, bypass halves it
  assign div_lim = pll_on_ff ? DIV_ON_M1 : DIV_OFF_M1;

  // Source period enable pulse
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      div_ff <= 16'h0000;
      src_tick_ff <= 1'b0;
    end
    else if (div_ff >= div_lim)
    begin
      div_ff <= 16'h0000;
      src_tick_ff <= 1'b1;
    end
    else
    begin
      div_ff <= div_ff + 16'h0001;
      src_tick_ff <= 1'b0;
    end
  end

  // Shared prescaler chain
  wtp_prescaler #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .mclk(mclk),
    .resetn(resetn),
    .src_tick(src_tick_ff),
    .phase(phase),
    .wdg_tick(wdg_tick),
    .slow_tick(slow_tick),
    .halt_tick(halt_tick)
  );

  // Bounds for the pending reload, using the live timebase
  assign ctrl_wr = wr && (addr == REG_WDG_CTRL);
  assign tbc = tb_lookup(timebase_select_ff);
  assign dmin = tmo_bound(ctrl_wr ? wdata[5:0] : reload_count_ff, tbc, 1'b0);
  assign dmax = tmo_bound(ctrl_wr ? wdata[5:0] : reload_count_ff, tbc, 1'b1);

  // Position in the window follows the unknown prescaler phase
  assign spread = (DLY_W+PRESC_W)'(dmax - dmin) * (DLY_W+PRESC_W)'(PHASE_MAX - phase);
  assign nxt_remain = dmin + spread[DLY_W+PRESC_W-1:PRESC_W];

  // Reload on a control write while armed or enabling, and after expiry
  assign load = (ctrl_wr && (armed_ff || wdata[CTRL_EN_BIT])) || expire;
  assign expire = armed_ff && src_tick_ff && (remain_ff == DLY_W'(1)) && !ctrl_wr;

  // Control and timebase registers
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      reload_count_ff <= RELOAD_RST;
      timebase_select_ff <= TB_RST;
    end
    else if (wr)
    begin
      if (addr == REG_WDG_CTRL)
        reload_count_ff <= wdata[5:0];
      if (addr == REG_MCC)
        timebase_select_ff <= wdata[1:0];
    end
  end

  // Enable is sticky until reset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      armed_ff <= 1'b0;
    else if (ctrl_wr && wdata[CTRL_EN_BIT])
      armed_ff <= 1'b1;
  end

  // Countdown in source periods
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      remain_ff <= '0;
    else if (load)
      remain_ff <= nxt_remain;
    else if (armed_ff && src_tick_ff)
      remain_ff <= remain_ff - DLY_W'(1);
  end

  // Prescaled periods since the last reload, saturating
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ticks_ff <= 7'h00;
    else if (load)
      ticks_ff <= 7'h00;
    else if (wdg_tick && (ticks_ff != 7'h7f))
      ticks_ff <= ticks_ff + 7'h01;
  end

  // System reset pulse on expiry
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pulse_ff <= 8'h00;
      sys_reset_n_ff <= 1'b1;
    end
    else if (expire)
    begin
      pulse_ff <= RST_PULSE_M1;
      sys_reset_n_ff <= 1'b0;
    end
    else if (pulse_ff != 8'h00)
      pulse_ff <= pulse_ff - 8'h01;
    else
      sys_reset_n_ff <= 1'b1;
  end

  // Sticky expiry flag, write one clears, a new expiry wins
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rst_flag_ff <= 1'b0;
    else if (expire)
      rst_flag_ff <= 1'b1;
    else if (wr && (addr == REG_STATUS) && wdata[STAT_RSTF_BIT])
      rst_flag_ff <= 1'b0;
  end

  // Read data register, unmapped addresses read zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else if (rd)
    begin
      unique case (addr)
        REG_WDG_CTRL: rdata_ff <= {armed_ff, 1'b0, reload_count_ff};
        REG_MCC: rdata_ff <= {6'h00, timebase_select_ff};
        REG_STATUS: rdata_ff <= {5'h00, pll_on_ff, rst_flag_ff, armed_ff};
        REG_TICKS: rdata_ff <= {1'b0, ticks_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  // PLL state output
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      pll_active_ff <= 1'b0;
    else
      pll_active_ff <= pll_on_ff;
  end

  assign rdata = rdata_ff;
  assign sys_reset_n = sys_reset_n_ff;
  assign pll_active = pll_active_ff;

endmodule

// ===== shared/wtp_pkg.sv
package wtp_pkg;

  // System clock rate and default oscillator rate
  localparam int MCLK_KHZ = 200000;
  localparam int OSC_KHZ_DEF = 4000;
  // Oscillator window in which the PLL doubles
  localparam int PLL_MIN_KHZ = 2000;
  localparam int PLL_MAX_KHZ = 4000;

  // Prescaler chain and timeout arithmetic
  localparam int PRESC_W = 14;
  localparam int DLY_W = 22;
  localparam logic [21:0] PRESC_PERIODS = 22'h004000;
  localparam logic [21:0] MIN_BASE_ADD = 22'h000080;
  localparam logic [21:0] SEG_ADD = 22'h0000c0;
  localparam int SEG_SHIFT = 6;
  localparam logic [13:0] PHASE_MAX = 14'h3fff;
  localparam int SLOW_TAP = 4;
  localparam int HALT_TAP = 11;

  // Timebase constant pair
  typedef struct packed {
    logic [5:0] msb;
    logic [5:0] lsb;
  } wtp_tb_const_t;

  localparam wtp_tb_const_t TB_2MS = '{msb: 6'h04, lsb: 6'h3b};
  localparam wtp_tb_const_t TB_4MS = '{msb: 6'h08, lsb: 6'h35};
  localparam wtp_tb_const_t TB_10MS = '{msb: 6'h14, lsb: 6'h23};
  localparam wtp_tb_const_t TB_25MS = '{msb: 6'h31, lsb: 6'h36};

  // Register offsets
  localparam logic [7:0] REG_WDG_CTRL = 8'h00;
  localparam logic [7:0] REG_MCC = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_TICKS = 8'h03;

  // Field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_RSTF_BIT = 1;
  localparam int STAT_PLL_BIT = 2;

  // Reset values
  localparam logic [5:0] RELOAD_RST = 6'h3f;
  localparam logic [1:0] TB_RST = 2'h0;

  // Length of the outgoing reset pulse in mclk cycles
  localparam int RST_PULSE_DEF = 16;

endpackage

// ===== design/wtp_prescaler.sv
`timescale 1ns/100ps

module wtp_prescaler
  import wtp_pkg::*;
#(
  parameter int WIDTH = PRESC_W
)
(
  input wire logic mclk,                 // System clock
  input wire logic resetn,               // Synchronous reset, active low
  input wire logic src_tick,             // One pulse per source period
  output logic [WIDTH-1:0] phase,        // Free running chain value
  output logic wdg_tick,                 // Pulse at chain wrap
  output logic slow_tick,                // Slow-mode tap pulse
  output logic halt_tick                 // Active-halt tap pulse
);

  logic [WIDTH-1:0] nxt_phase;

  assign nxt_phase = phase + {{(WIDTH-1){1'b0}}, 1'b1};

  // One chain serves watchdog, halt wake-up and slow mode
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      phase <= '0;
    else if (src_tick)
      phase <= nxt_phase;
  end

  // Wrap of the full chain gives the divide by 16384
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wdg_tick <= 1'b0;
    else
      wdg_tick <= src_tick && (phase == {WIDTH{1'b1}});
  end

  // Rising edges of the lower taps for the other timers
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      slow_tick <= 1'b0;
      halt_tick <= 1'b0;
    end
    else
    begin
      slow_tick <= src_tick && nxt_phase[SLOW_TAP] && !phase[SLOW_TAP];
      halt_tick <= src_tick && nxt_phase[HALT_TAP] && !phase[HALT_TAP];
    end
  end

endmodule

// ===== verif/wtp_watchdog_assertions.sv
`timescale 1ns/100ps

module wtp_watchdog_assertions
  import wtp_pkg::*;
#(
  parameter int OSC_KHZ = OSC_KHZ_DEF,
  parameter int RST_PULSE = RST_PULSE_DEF
)
(
  input wire logic mclk,         // Clock
  input wire logic resetn,       // Reset
  input wire logic [7:0] addr,   // Address
  input wire logic [7:0] wdata,  // Write data
  input wire logic wr,           // Write strobe
  input wire logic rd,           // Read strobe
  input wire logic [7:0] rdata,  // Read data
  input wire logic pll_option,   // Strap
  input wire logic sys_reset_n,  // Reset request
  input wire logic pll_active,   // PLL on
  input wire logic slow_tick,    // Slow pulse
  input wire logic halt_tick     // Halt pulse
);
  int div;
  int lo_cnt_ff;
  int sc_ff;
  logic seen_ff;
  logic pll_q_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Source period in mclk cycles
  assign div = pll_active ? 100000 / OSC_KHZ : 400000 / OSC_KHZ;

  // Cycles the reset request has been low
  always_ff @(posedge mclk)
  begin
    if (!resetn || sys_reset_n)
      lo_cnt_ff <= 0;
    else
      lo_cnt_ff <= lo_cnt_ff + 1;
  end

  // Gap since the last slow tick; a rate change voids it
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sc_ff <= 0;
      seen_ff <= 1'b0;
    end
    else
    begin
      sc_ff <= slow_tick ? 0 : sc_ff + 1;
      seen_ff <= (seen_ff | slow_tick) & (pll_active == pll_q_ff);
    end
  end

  // Previous PLL state
  always_ff @(posedge mclk)
    pll_q_ff <= pll_active;

  chk_pulse_len: assert property ($rose(sys_reset_n) |-> lo_cnt_ff == RST_PULSE)
    else $error("reset pulse length wrong");
  chk_slow_single: assert property (slow_tick |=> !slow_tick)
    else $error("slow tick too long");
  chk_slow_space: assert property (slow_tick && seen_ff |-> sc_ff == 32 * div - 1)
    else $error("slow tick spacing wrong");
  chk_halt_phase: assert property (halt_tick && seen_ff |-> sc_ff >= 16 * div - 2 && sc_ff <= 16 * div)
    else $error("halt tick off the shared chain");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_unmapped_zero: assert property (rd && addr > REG_TICKS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_back: assert property (wr && addr == REG_WDG_CTRL ##1 !wr ##1 rd && addr == REG_WDG_CTRL |=>
    rdata[5:0] == $past(wdata[5:0], 3) && (rdata[CTRL_EN_BIT] || !$past(wdata[CTRL_EN_BIT], 3)))
    else $error("control readback wrong");
  chk_tb_back: assert property (wr && addr == REG_MCC ##1 !wr ##1 rd && addr == REG_MCC |=>
    rdata == {6'h00, $past(wdata[1:0], 3)})
    else $error("timebase readback wrong");
  chk_pll_status: assert property (rd && addr == REG_STATUS |=>
    rdata[STAT_PLL_BIT] == pll_active && rdata[7:3] == 5'h00)
    else $error("status PLL bit wrong");
  chk_pll_range: assert property (pll_active |-> pll_option && OSC_KHZ >= PLL_MIN_KHZ && OSC_KHZ <= PLL_MAX_KHZ)
    else $error("PLL engaged out of range");

  cover property ($fell(sys_reset_n));
  cover property (halt_tick);
  cover property (rd && addr == REG_STATUS ##1 rdata[STAT_RSTF_BIT]);
endmodule

bind wtp_watchdog wtp_watchdog_assertions #(.OSC_KHZ(OSC_KHZ), .RST_PULSE(RST_PULSE)) u_chk (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pll_option(pll_option), .sys_reset_n(sys_reset_n), .pll_active(pll_active),
  .slow_tick(slow_tick), .halt_tick(halt_tick));

// ===== verif/wtp_watchdog_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module wtp_watchdog_tb
  import wtp_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic sys_reset_n;
  logic pll_active;
  logic pll_active2;
  logic slow_tick;
  logic halt_tick;
  logic low_seen;
  logic strap = 1'b1;
  int failures = 0;
  int n_tests = 0;
  int n;
  int lo;
  int hi;
  // Reads right after reset: address, expected value
  logic [15:0] rows [6] = '{{REG_WDG_CTRL, 2'b00, RELOAD_RST}, {REG_MCC, 8'h00},
    {REG_STATUS, 8'h00}, {REG_TICKS, 8'h00}, {8'h10, 8'h00}, {8'hff, 8'h00}};
  // Timeout cases: timebase in [7:6], count in [5:0]
  logic [7:0] tc [2] = '{8'h02, 8'h40};

  // Clock generation
  always #2.5 mclk = ~mclk;

  // Oscillator outside the PLL window: source runs at mclk rate
  wtp_watchdog #(.OSC_KHZ(400000)) dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pll_option(1'b1), .sys_reset_n(sys_reset_n),
    .pll_active(pll_active), .slow_tick(slow_tick), .halt_tick(halt_tick));
  // Default crystal oscillator, PLL strap driven by the bench
  wtp_watchdog dut2 (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(), .pll_option(strap), .sys_reset_n(), .pll_active(pll_active2), .slow_tick(),
    .halt_tick());

  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Cycles until the reset request drops, bounded
  task automatic wait_low();
    n = 0;
    while (sys_reset_n !== 1'b0 && n < 60000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // Timeout window in source periods, integer division truncating
  function automatic void bounds(input logic [1:0] tb, input int cnt, output int lo_o, output int hi_o);
    wtp_tb_const_t c;
    int m;
    int l;
    int k;
    int seg;
    c = (tb == 2'h0) ? TB_2MS : (tb == 2'h1) ? TB_4MS : (tb == 2'h2) ? TB_10MS : TB_25MS;
    m = int'(c.msb);
    l = int'(c.lsb);
    k = 4 * cnt / m;
    seg = 16384 * (cnt - k) + (192 + l) * 64 * k;
    lo_o = (l + 128) * 64 + ((cnt < m / 4) ? 16384 * cnt : seg);
    hi_o = 16384 + ((cnt <= m / 4) ? 16384 * cnt : seg);
  endfunction

  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[i])
      rd_chk(rows[i][15:8], rows[i][7:0]);
    repeat (8) @(posedge mclk);
    #1;
    `CHK(pll_active, 1'b0)
    `CHK(pll_active2, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(REG_MCC, 8'hfc | 8'(i));
      rd_chk(REG_MCC, 8'(i));
    end
    wr_reg(REG_WDG_CTRL, 8'h05);
    rd_chk(REG_WDG_CTRL, 8'h05);
    rd_chk(REG_STATUS, 8'h00);
    // Second reset in mid-run with the strap now low
    @(posedge mclk);
    resetn <= 1'b0;
    strap <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK(pll_active2, 1'b0)
    `CHK(sys_reset_n, 1'b1)
    rd_chk(REG_WDG_CTRL, 8'h3f);
    wr_reg(REG_MCC, 8'h00);
    wr_reg(REG_WDG_CTRL, 8'h80);
    low_seen = 1'b0;
    for (int i = 0; i < 17000; i++)
    begin
      @(posedge mclk);
      #1;
      low_seen |= !sys_reset_n;
      if (i == 8000)
        wr_reg(REG_WDG_CTRL, 8'h00);
    end
    `CHK(low_seen, 1'b0)
    rd_chk(REG_WDG_CTRL, 8'h80);
    // Chain restarted at the reset, so exactly one wrap since the refresh
    rd_chk(REG_TICKS, 8'h01);
    foreach (tc[i])
    begin
      wr_reg(REG_MCC, {6'h00, tc[i][7:6]});
      wr_reg(REG_WDG_CTRL, {2'b10, tc[i][5:0]});
      bounds(tc[i][7:6], int'(tc[i][5:0]), lo, hi);
      wait_low();
      `CHK(n >= lo && n <= hi + 3, 1'b1)
      repeat (RST_PULSE_DEF + 1) @(posedge mclk);
      #1;
      `CHK(sys_reset_n, 1'b1)
      rd_chk(REG_STATUS, 8'h03);
      wr_reg(REG_STATUS, 8'h02);
      rd_chk(REG_STATUS, 8'h01);
    end
    summarize();
  end

  // Cut a hung run short
  initial
  begin
    #480000;
    failures++;
    summarize();
  end
endmodule
